// [logic/asr_pkg.sv]
// package for the static ram host controller: timing constants, request and ram pin carriers, states
`default_nettype none
package asr_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CLK_PERIOD_NS = 4;
  // cycle time of the slowest speed grade, in ns
  localparam int unsigned CYCLE_NS = 450;
  localparam int unsigned CYCLE_CLKS = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // write pulse width, and address valid before write enable rises, in ns
  localparam int unsigned WR_PULSE_NS = 200;
  localparam int unsigned WR_PULSE_CLKS = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ADDR_VALID_NS = 230;
  localparam int unsigned ADDR_VALID_CLKS = (ADDR_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // setup to the falling edge is zero; the lead only fills the address valid window
  localparam int unsigned ADDR_SU_CLKS = ADDR_VALID_CLKS - WR_PULSE_CLKS;
  // recovery after standby: five cycle times
  localparam int unsigned WAKE_CYCLES = 5;
  localparam int unsigned WAKE_CLKS = WAKE_CYCLES * CYCLE_CLKS;
  localparam int unsigned CNT_W = 10;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic data;
  } asr_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic chip_sel_n;
    logic wr_en_n;
    logic data_in;
  } asr_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WRITE = 3'b010,
    ST_HOLD  = 3'b011,
    ST_READ  = 3'b100,
    ST_SLEEP = 3'b101,
    ST_WAKE  = 3'b110
  } asr_state_t;
endpackage : asr_pkg
`default_nettype wire

// [logic/asr_host.sv]
// host controller that runs read and write cycles on a 4096 by 1 static ram
`default_nettype none
// Operation
// [R01] one bit at each of 4096 addresses
// [R02] address held steady through every write
// [R03] chip select low enables data paths
// [R04] write enable high reads, low writes
// [R05] write enable high whenever address changes
// [R06] data stored while selected and writing
// [R07] output floats during write cycles
// [R08] read data equals last written bit
// [R09] output continuously shows addressed bit
// [R10] chip select may stay low permanently
// [R11] select and write enable high in standby
// [R12] standby keeps data, no access
// [R13] wait five cycle times after standby
// [R14] output follows address; contents start undefined
module asr_host #(
  parameter int unsigned WAKE_CLKS = asr_pkg::WAKE_CLKS
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // user request side
  input wire logic req_valid,
  output logic req_ready,
  input wire asr_pkg::asr_req_t req,
  output logic rd_valid,
  output logic rd_data,
  // standby control
  input wire logic standby_req,
  output logic standby_ack,
  // ram pins
  output asr_pkg::asr_pins_t ram,
  input wire logic ram_q
);
  // a zero wake count would let an access through straight after standby
  if (WAKE_CLKS < 1 || WAKE_CLKS >= (1 << 16))
  begin : g_wake_range
    $error("WAKE_CLKS out of range");
  end

  asr_pkg::asr_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [asr_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic din_q, din_d;
  logic wen_n_q, wen_n_d;
  logic cs_n_q, cs_n_d;
  logic rdv_q, rdv_d;
  logic rdd_q, rdd_d;
  logic [2:0] q_sync_q;

  // countdown helpers: a load of zero or one ends at the next edge
  function automatic logic [15:0] cnt_dec(input logic [15:0] c);
    return c - 16'h1;
  endfunction : cnt_dec

  function automatic logic cnt_last(input logic [15:0] c);
    return c <= 16'h1;
  endfunction : cnt_last

  // ram output arrives asynchronously: three stages, change taken once last two agree
  // the filter costs a cycle but hides an output that is still settling
  logic q_stable_q, q_stable_d;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      q_sync_q <= 3'h0;
    else
      q_sync_q <= {q_sync_q[1:0], ram_q};
  end

  always_comb
  begin
    q_stable_d = q_stable_q;
    if (q_sync_q[2] == q_sync_q[1])
      q_stable_d = q_sync_q[2];
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      q_stable_q <= 1'b0;
    else
      q_stable_q <= q_stable_d;
  end

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    din_d = din_q;
    wen_n_d = wen_n_q;
    cs_n_d = cs_n_q;
    rdv_d = 1'b0;
    rdd_d = rdd_q;
    unique case (state_q)
      asr_pkg::ST_IDLE:
      begin
        wen_n_d = 1'b1; // [R05]
        cs_n_d = 1'b0; // [R10]
        // standby outranks a waiting request so the ram is parked promptly
        if (standby_req)
        begin
          cs_n_d = 1'b1; // [R11]
          state_d = asr_pkg::ST_SLEEP;
        end
        else if (req_valid)
        begin
          addr_d = req.addr; // [R01]
          din_d = req.data;
          cnt_d = 16'(asr_pkg::ADDR_SU_CLKS);
          state_d = req.wr ? asr_pkg::ST_SETUP : asr_pkg::ST_READ; // [R04]
          if (!req.wr)
            cnt_d = 16'(asr_pkg::CYCLE_CLKS + 3);
        end
      end
      asr_pkg::ST_SETUP:
      begin
        cnt_d = cnt_dec(cnt_q);
        if (cnt_last(cnt_q))
        begin
          wen_n_d = 1'b0; // [R06]
          cnt_d = 16'(asr_pkg::WR_PULSE_CLKS);
          state_d = asr_pkg::ST_WRITE;
        end
      end
      asr_pkg::ST_WRITE:
      begin
        // address and data untouched here; ram output floats meanwhile
        cnt_d = cnt_dec(cnt_q); // [R02] [R07]
        if (cnt_last(cnt_q))
        begin
          wen_n_d = 1'b1;
          cnt_d = 16'(asr_pkg::CYCLE_CLKS);
          state_d = asr_pkg::ST_HOLD;
        end
      end
      asr_pkg::ST_HOLD:
      begin
        // wait a full cycle time after write enable rises before the address may move
        cnt_d = cnt_dec(cnt_q); // [R02]
        if (cnt_last(cnt_q))
          state_d = asr_pkg::ST_IDLE;
      end
      asr_pkg::ST_READ:
      begin
        // access time plus synchroniser latency before sampling
        // sampling earlier would hand back the bit of the previous address
        cnt_d = cnt_dec(cnt_q); // [R09]
        if (cnt_last(cnt_q))
        begin
          rdv_d = 1'b1;
          rdd_d = q_stable_q; // [R08] [R14]
          state_d = asr_pkg::ST_IDLE;
        end
      end
      asr_pkg::ST_SLEEP:
      begin
        // no access while parked; the ram alone keeps its contents
        cs_n_d = 1'b1; // [R11] [R12]
        wen_n_d = 1'b1;
        if (!standby_req)
        begin
          cnt_d = 16'(WAKE_CLKS);
          state_d = asr_pkg::ST_WAKE;
        end
      end
      asr_pkg::ST_WAKE:
      begin
        // select stays high until the ram has settled at full supply
        cnt_d = cnt_dec(cnt_q); // [R13]
        if (cnt_last(cnt_q))
        begin
          cs_n_d = 1'b0;
          state_d = asr_pkg::ST_IDLE;
        end
      end
      default:
        state_d = asr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= asr_pkg::ST_IDLE;
      cnt_q <= 16'h0;
      addr_q <= asr_pkg::ADDR_RST;
      din_q <= 1'b0;
      wen_n_q <= 1'b1;
      cs_n_q <= 1'b1;
      rdv_q <= 1'b0;
      rdd_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      din_q <= din_d;
      wen_n_q <= wen_n_d;
      cs_n_q <= cs_n_d;
      rdv_q <= rdv_d;
      rdd_q <= rdd_d;
    end
  end

  assign req_ready = (state_q == asr_pkg::ST_IDLE) && !standby_req;
  assign standby_ack = (state_q == asr_pkg::ST_SLEEP);
  assign rd_valid = rdv_q;
  assign rd_data = rdd_q;
  // one driver for the whole pin bundle
  assign ram = '{
    addr: addr_q,
    chip_sel_n: cs_n_q, // [R03]
    wr_en_n: wen_n_q,
    data_in: din_q
  };
endmodule : asr_host
`default_nettype wire

// [bench/asr_ram_m.sv]
// behavioural 4096 by 1 static ram seen from the host pins
`default_nettype none
module asr_ram_m (
  // pins
  input wire asr_pkg::asr_pins_t ram,
  output logic q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mem [4096];
  always @*
    if (!ram.chip_sel_n && !ram.wr_en_n)
      mem[ram.addr] = ram.data_in;
  // a floated output shows the inverse so a stale value never passes
  assign q = (!ram.chip_sel_n && ram.wr_en_n) ? mem[ram.addr] : ~mem[ram.addr];
endmodule : asr_ram_m
`default_nettype wire

// [bench/asr_host_props.sv]
// port assertions for the static ram host controller
`default_nettype none
module asr_host_props (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // user and ram sides
  input wire logic req_valid,
  input wire logic req_ready,
  input wire asr_pkg::asr_req_t req,
  input wire logic rd_valid,
  input wire logic rd_data,
  input wire logic standby_ack,
  input wire asr_pkg::asr_pins_t ram,
  input wire logic ram_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire logic rd_take = req_valid && req_ready && !req.wr;
  wire logic wr_take = req_valid && req_ready && req.wr;
  property p_as; !ram.wr_en_n |-> $stable(ram.addr); endproperty
  property p_wa; $changed(ram.addr) |-> ram.wr_en_n; endproperty
  property p_sb; standby_ack |-> ram.chip_sel_n && ram.wr_en_n; endproperty
  property p_nr; standby_ack |-> !req_ready; endproperty
  property p_wk; $fell(standby_ack) |-> ram.chip_sel_n [*3]; endproperty
  // answer stands one edge after the last count: access wait plus three sync stages
  property p_rl; rd_take |-> ##117 rd_valid; endproperty
  property p_wp; $fell(ram.wr_en_n) |-> ##50 $rose(ram.wr_en_n); endproperty
  property p_cs; rd_valid |-> !ram.chip_sel_n; endproperty
  // the bit handed back is the ram output five edges earlier, through the filter
  property p_rd; rd_valid |-> rd_data == $past(ram_q, 5); endproperty
  // write enable falls after the address lead of eight cycles
  property p_ws; wr_take |-> ##9 $fell(ram.wr_en_n); endproperty
  property p_we; !ram.wr_en_n |-> !ram.chip_sel_n; endproperty
  a_as: assert property (p_as) else $error("addr moved in write");
  a_wa: assert property (p_wa) else $error("addr moved with we low");
  a_sb: assert property (p_sb) else $error("standby pins");
  a_nr: assert property (p_nr) else $error("ready in standby");
  a_wk: assert property (p_wk) else $error("wake too short");
  a_rl: assert property (p_rl) else $error("read latency");
  a_wp: assert property (p_wp) else $error("write pulse");
  a_cs: assert property (p_cs) else $error("read deselected");
  a_rd: assert property (p_rd) else $error("read data differs from ram output");
  a_ws: assert property (p_ws) else $error("write enable late or missing");
  a_we: assert property (p_we) else $error("write while deselected");
  c_rd: cover property (rd_valid);
  c_wr: cover property ($fell(ram.wr_en_n));
  c_sb: cover property (standby_ack);
  c_wk: cover property ($fell(standby_ack));
endmodule : asr_host_props
bind asr_host asr_host_props u_props (.clock(clock), .arst_n(arst_n),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_valid(rd_valid),
  .rd_data(rd_data), .standby_ack(standby_ack), .ram(ram), .ram_q(ram_q));
`default_nettype wire

// [bench/tb_top.sv]
// testbench for the static ram host controller
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, arst_n = 0, req_valid = 0, standby_req = 0;
  logic req_ready, rd_valid, rd_data, standby_ack, ram_q, q;
  asr_pkg::asr_req_t req = '0;
  asr_pkg::asr_pins_t ram;
  int n_fail = 0, compares = 0, cyc = 0;
  // short wake keeps the run brief; the counting logic is the same
  localparam int WAKE = 4;
  asr_host #(.WAKE_CLKS(WAKE)) dut_u (.clock(clock), .arst_n(arst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rd_valid(rd_valid),
    .rd_data(rd_data), .standby_req(standby_req), .standby_ack(standby_ack),
    .ram(ram), .ram_q(ram_q));
  asr_ram_m ram_u (.ram(ram), .q(ram_q));
  initial forever #2 clock = ~clock;
  task automatic stop_test;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic chk(string what, logic e, logic g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s exp %b got %b", what, e, g);
    end
  endtask : chk
  // one request; a read waits for its answer pulse
  task automatic access(logic wr, logic [11:0] a, logic d);
    while (req_ready !== 1'b1) @(negedge clock);
    req_valid = 1;
    req = '{wr, a, d};
    @(negedge clock);
    req_valid = 0;
    while (!wr && rd_valid !== 1'b1) @(negedge clock);
    q = rd_data;
    @(negedge clock);
  endtask : access
  task automatic t_rw;
    for (int i = 0; i < 4; i++)
      access(1'b1, 12'h555 * i[11:0], i[0]);
    for (int i = 0; i < 4; i++)
    begin
      access(1'b0, 12'h555 * i[11:0], 1'b0);
      chk("rd", i[0], q);
    end
    access(1'b1, 12'hfff, 1'b0);
    access(1'b0, 12'hfff, 1'b1);
    chk("ovw", 1'b0, q);
    chk("cs_low", 1'b0, ram.chip_sel_n);
  endtask : t_rw
  task automatic t_standby;
    int n;
    n = 0;
    access(1'b1, 12'h123, 1'b1);
    // standby is only taken once the write has finished
    while (req_ready !== 1'b1) @(negedge clock);
    standby_req = 1;
    @(negedge clock);
    chk("ack", 1'b1, standby_ack);
    chk("cs", 1'b1, ram.chip_sel_n);
    chk("we", 1'b1, ram.wr_en_n);
    chk("rdy", 1'b0, req_ready);
    standby_req = 0;
    while (req_ready !== 1'b1)
    begin
      @(negedge clock);
      n++;
    end
    compares++;
    if (n != WAKE + 1)
    begin
      n_fail++;
      $display("BAD wake exp %0d got %0d", WAKE + 1, n);
    end
    access(1'b0, 12'h123, 1'b0);
    chk("keep", 1'b1, q);
  endtask : t_standby
  // reset in mid-write must park the pins; ram contents are untouched
  task automatic t_reset;
    access(1'b1, 12'h0f0, 1'b1);
    repeat (20) @(negedge clock);
    chk("wlow", 1'b0, ram.wr_en_n);
    arst_n = 0;
    @(negedge clock);
    chk("rcs", 1'b1, ram.chip_sel_n);
    chk("rwe", 1'b1, ram.wr_en_n);
    chk("rrv", 1'b0, rd_valid);
    chk("rrdy", 1'b1, req_ready);
    arst_n = 1;
    access(1'b0, 12'h555, 1'b0);
    chk("rkeep", 1'b1, q);
  endtask : t_reset
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      stop_test;
    end
  end
  initial
  begin
    repeat (4) @(negedge clock);
    arst_n = 1;
    t_rw;
    t_standby;
    t_reset;
    stop_test;
  end
endmodule : tb_top
`default_nettype wire
